/* hdl/analog_comparator_control.sv */
// Analog comparator control, result synchroniser, events and bus slave.
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps

module analog_comparator_control
(
   // Clock, reset and clock enable.
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // AHB-Lite slave port.
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Analog comparator and pins, asynchronous to mclk.
   input wire logic cmp_raw,
   input wire logic cmp_positive_pin_in,
   input wire logic cmp_negative_pin_in,
   // Converter and CPU state, on mclk.
   input wire logic converter_enable,
   input wire logic channel_select_top,
   input wire logic [2:0] channel_select_low,
   input wire logic global_irq_enable,
   input wire logic irq_vector_ack,
   // Analog controls.
   output logic cmp_power_off,
   output logic bandgap_select,
   output logic negative_mux_select,
   output logic [2:0] negative_channel,
   output logic negative_pin_buffer_off,
   output logic positive_pin_buffer_off,
   // Port input register bits of the two pins.
   output logic cmp_positive_pin_read,
   output logic cmp_negative_pin_read,
   // Timer capture feed and interrupt.
   output logic capture_input,
   output logic cmp_irq
);

   // Software-visible state.
   logic power_off_r;
   logic bandgap_r;
   logic flag_r;
   logic irq_en_r;
   logic capture_en_r;
   logic [1:0] mode_r;
   logic mux_en_r;
   logic neg_buf_off_r;
   logic pos_buf_off_r;

   // Synchronisers and edge history.
   logic cmp_meta_r;
   logic cmp_sync_r;
   logic cmp_prev_r;
   logic [2:0] hist_valid_r;
   logic pos_meta_r;
   logic pos_sync_r;
   logic neg_meta_r;
   logic neg_sync_r;

   // Bus data-phase state.
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic addr_phase;
   logic [7:0] ctrl_status_rd;
   logic [31:0] rd_nxt;
   logic wr_ctrl;
   logic wr_convb;
   logic wr_pins;

   // Event detection.
   logic rise;
   logic fall;
   logic event_hit;
   logic flag_nxt;

   // A transfer is taken only on a NONSEQ that the bus lets through.
   assign addr_phase = hsel && hready
                       && (htrans == cmp_ctrl_pkg::HTRANS_NONSEQ);
   assign wr_ctrl = wr_pend_r && (wr_addr_r == cmp_ctrl_pkg::ADDR_CTRL_STATUS);
   assign wr_convb = wr_pend_r
                     && (wr_addr_r == cmp_ctrl_pkg::ADDR_CONV_CTRL_B);
   assign wr_pins = wr_pend_r && (wr_addr_r == cmp_ctrl_pkg::ADDR_PIN_DISABLE);

   // Control byte as read; the result bit is the synchronised output.
   assign ctrl_status_rd = {power_off_r, bandgap_r, cmp_sync_r, flag_r,
                            irq_en_r, capture_en_r, mode_r};

   // Read data is built in the address phase so it stands in a flop.
   always_comb
   begin
      rd_nxt = 32'h0000_0000;
      case (haddr)
         cmp_ctrl_pkg::ADDR_CTRL_STATUS: rd_nxt[7:0] = ctrl_status_rd;
         cmp_ctrl_pkg::ADDR_CONV_CTRL_B:
            rd_nxt[cmp_ctrl_pkg::POS_MUX_EN] = mux_en_r;
         cmp_ctrl_pkg::ADDR_PIN_DISABLE:
         begin
            rd_nxt[cmp_ctrl_pkg::POS_NEG_BUF_OFF] = neg_buf_off_r;
            rd_nxt[cmp_ctrl_pkg::POS_POS_BUF_OFF] = pos_buf_off_r;
         end
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   // Zero-wait slave: always ready, always OKAY, unmapped reads give zero.
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         hreadyout <= 1'h1;
         hresp <= cmp_ctrl_pkg::HRESP_OKAY;
         hrdata <= 32'h0000_0000;
         wr_pend_r <= 1'h0;
         wr_addr_r <= 8'h00;
      end
      else if (ce)
      begin
         hreadyout <= 1'h1;
         hresp <= cmp_ctrl_pkg::HRESP_OKAY;
         wr_pend_r <= addr_phase && hwrite;
         if (addr_phase)
         begin
            wr_addr_r <= haddr;
            hrdata <= hwrite ? 32'h0000_0000 : rd_nxt;
         end
      end
   end

   // Plain control fields written in the data phase.
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         {power_off_r, bandgap_r} <= cmp_ctrl_pkg::RESET_CTRL_STATUS[7:6];
         {irq_en_r, capture_en_r, mode_r} <=
            cmp_ctrl_pkg::RESET_CTRL_STATUS[3:0];
         mux_en_r <= cmp_ctrl_pkg::RESET_CONV_CTRL_B[cmp_ctrl_pkg::POS_MUX_EN];
         {neg_buf_off_r, pos_buf_off_r} <=
            cmp_ctrl_pkg::RESET_PIN_DISABLE[1:0];
      end
      else if (ce)
      begin
         if (wr_ctrl)
         begin
            power_off_r <= hwdata[cmp_ctrl_pkg::POS_POWER_OFF];
            bandgap_r <= hwdata[cmp_ctrl_pkg::POS_BANDGAP];
            irq_en_r <= hwdata[cmp_ctrl_pkg::POS_IRQ_EN];
            capture_en_r <= hwdata[cmp_ctrl_pkg::POS_CAPTURE];
            mode_r <= hwdata[cmp_ctrl_pkg::POS_MODE_HI:
                             cmp_ctrl_pkg::POS_MODE_LO];
         end
         if (wr_convb)
            mux_en_r <= hwdata[cmp_ctrl_pkg::POS_MUX_EN];
         if (wr_pins)
         begin
            neg_buf_off_r <= hwdata[cmp_ctrl_pkg::POS_NEG_BUF_OFF];
            pos_buf_off_r <= hwdata[cmp_ctrl_pkg::POS_POS_BUF_OFF];
         end
      end
   end

   // Two-flop synchronisers for the comparator and the two pin buffers.
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         cmp_meta_r <= 1'h0;
         cmp_sync_r <= 1'h0;
         pos_meta_r <= 1'h0;
         pos_sync_r <= 1'h0;
         neg_meta_r <= 1'h0;
         neg_sync_r <= 1'h0;
      end
      else if (ce)
      begin
         cmp_meta_r <= cmp_raw;
         cmp_sync_r <= cmp_meta_r;
         pos_meta_r <= cmp_positive_pin_in;
         pos_sync_r <= pos_meta_r;
         neg_meta_r <= cmp_negative_pin_in;
         neg_sync_r <= neg_meta_r;
      end
   end

   // Edge history; events wait three cycles after reset or power-up; after reset
   // the history then holds real samples, but after power-up cmp_prev_r can still hold the off-state zero.
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         cmp_prev_r <= 1'h0;
         hist_valid_r <= 3'h0;
      end
      else if (ce)
      begin
         cmp_prev_r <= cmp_sync_r;
         hist_valid_r <= {hist_valid_r[1:0], !power_off_r};
      end
   end

   // One event at most per cycle, chosen by the mode; reserved flags none.
   assign rise = cmp_sync_r && !cmp_prev_r;
   assign fall = !cmp_sync_r && cmp_prev_r;
   always_comb
   begin
      case (mode_r)
         cmp_ctrl_pkg::MODE_TOGGLE: event_hit = rise || fall;
         cmp_ctrl_pkg::MODE_FALLING: event_hit = fall;
         cmp_ctrl_pkg::MODE_RISING: event_hit = rise;
         default: event_hit = 1'h0;
      endcase
      if (!hist_valid_r[2] || power_off_r)
         event_hit = 1'h0;
   end

   // The flag is sticky; a new event wins over a clear in the same cycle.
   always_comb
   begin
      flag_nxt = flag_r;
      if (irq_vector_ack || (wr_ctrl && hwdata[cmp_ctrl_pkg::POS_FLAG]))
         flag_nxt = 1'h0;
      if (event_hit)
         flag_nxt = 1'h1;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         flag_r <= cmp_ctrl_pkg::RESET_CTRL_STATUS[cmp_ctrl_pkg::POS_FLAG];
      else if (ce)
         flag_r <= flag_nxt;
   end

   // Registered outputs toward the analog macro, pins, timer and CPU.
   // Software must mask the interrupt around power-off and mode changes;
   // the block does not filter the glitch those changes can cause.
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         cmp_power_off <= 1'h0;
         bandgap_select <= 1'h0;
         negative_mux_select <= 1'h0;
         negative_channel <= cmp_ctrl_pkg::RESET_CHANNEL;
         negative_pin_buffer_off <= 1'h0;
         positive_pin_buffer_off <= 1'h0;
         cmp_positive_pin_read <= 1'h0;
         cmp_negative_pin_read <= 1'h0;
         capture_input <= 1'h0;
         cmp_irq <= 1'h0;
      end
      else if (ce)
      begin
         cmp_power_off <= power_off_r;
         bandgap_select <= bandgap_r;
         // Upper select bit set has no pin in the table: keep the pin.
         negative_mux_select <= mux_en_r && !converter_enable
                                && !channel_select_top;
         negative_channel <= channel_select_low;
         negative_pin_buffer_off <= neg_buf_off_r;
         positive_pin_buffer_off <= pos_buf_off_r;
         cmp_positive_pin_read <= pos_sync_r && !pos_buf_off_r;
         cmp_negative_pin_read <= neg_sync_r && !neg_buf_off_r;
         capture_input <= capture_en_r && cmp_sync_r;
         cmp_irq <= flag_nxt && irq_en_r && global_irq_enable;
      end
   end

   // Checks assume ce is high across each window they look at.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_result_sync: assert property (ce ##1 ce ##1 ce |->
      cmp_sync_r == $past(cmp_raw, 2))
      else $error("result not the raw output two cycles back");
   a_irq_gate: assert property (ce |=> cmp_irq ==
      ($past(flag_nxt) && $past(irq_en_r) && $past(global_irq_enable)))
      else $error("interrupt not flag and both enables");
   a_flag_set_wins: assert property (ce && event_hit |=> flag_r)
      else $error("event lost");
   a_flag_ack_clear: assert property (ce && irq_vector_ack
      && !event_hit |=> !flag_r)
      else $error("flag survived vector ack");
   a_flag_w1c: assert property (ce && wr_ctrl && hwdata[4]
      && !event_hit |=> !flag_r)
      else $error("flag survived written one");
   a_mode_rise: assert property (ce && mode_r == 2'h3 && fall
      && hist_valid_r[2] && !flag_r && !wr_ctrl |=> !flag_r)
      else $error("falling edge flagged in rising mode");
   a_mode_reserved: assert property (ce && mode_r == 2'h1
      |-> !event_hit)
      else $error("reserved mode flagged an event");
   a_neg_mux: assert property (ce && (!mux_en_r || converter_enable)
      |=> !negative_mux_select)
      else $error("converter pin selected while mux not allowed");
   a_buffer_read: assert property (ce && neg_buf_off_r
      |=> !cmp_negative_pin_read)
      else $error("disabled pin reads nonzero");
   a_capture_route: assert property (ce && !capture_en_r
      |=> !capture_input)
      else $error("capture fed while routing off");
   a_power_write: assert property (ce && wr_ctrl |=>
      power_off_r == $past(hwdata[7]))
      else $error("power-off bit not written");
   c_rise_event: cover property (ce && mode_r == 2'h3 && event_hit);
   c_irq_raised: cover property (ce && !cmp_irq ##1 cmp_irq);
   c_set_and_clear: cover property (ce && event_hit && irq_vector_ack);
   c_mux_selected: cover property (negative_mux_select);

endmodule : analog_comparator_control

/* hdl/cmp_ctrl_pkg.sv */
// Constants for the analog comparator control and status block.
package cmp_ctrl_pkg;

   // Byte addresses of the word-aligned registers.
   localparam logic [7:0] ADDR_CTRL_STATUS = 8'h50;
   localparam logic [7:0] ADDR_CONV_CTRL_B = 8'h54;
   localparam logic [7:0] ADDR_PIN_DISABLE = 8'h58;

   // Field positions in comparator_control_status.
   localparam int POS_POWER_OFF = 7;
   localparam int POS_BANDGAP = 6;
   localparam int POS_RESULT = 5;
   localparam int POS_FLAG = 4;
   localparam int POS_IRQ_EN = 3;
   localparam int POS_CAPTURE = 2;
   localparam int POS_MODE_HI = 1;
   localparam int POS_MODE_LO = 0;

   // Field positions in converter_control_b and pin_digital_input_disable.
   localparam int POS_MUX_EN = 6;
   localparam int POS_NEG_BUF_OFF = 1;
   localparam int POS_POS_BUF_OFF = 0;

   // Event mode codes.
   localparam logic [1:0] MODE_TOGGLE = 2'h0;
   localparam logic [1:0] MODE_RESERVED = 2'h1;
   localparam logic [1:0] MODE_FALLING = 2'h2;
   localparam logic [1:0] MODE_RISING = 2'h3;

   // Values after reset.
   localparam logic [7:0] RESET_CTRL_STATUS = 8'h00;
   localparam logic [7:0] RESET_CONV_CTRL_B = 8'h00;
   localparam logic [7:0] RESET_PIN_DISABLE = 8'h00;
   localparam logic [2:0] RESET_CHANNEL = 3'h0;

   // Bus constants.
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'h0;

endpackage : cmp_ctrl_pkg

/* tb/analog_comparator_control_tb.sv */
// Self-checking testbench for the comparator control block.
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) \
      begin \
         mismatches++; \
         $display("ERROR %0t got %h exp %h", $time, got, exp); \
      end \
   end

module analog_comparator_control_tb;
   typedef struct packed {
      logic bg;
      logic mux;
      logic cen;
      logic top;
      logic [2:0] ch;
      logic [11:0] vp;
      logic [11:0] vn;
      logic sel;
      logic res;
   } row_s;

   // Analog setups beside the result and select that they should give.
   row_s rows [8] = '{
      '{1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 12'h1F4, 12'h190, 1'b0, 1'b1},
      '{1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 12'h12C, 12'h190, 1'b0, 1'b0},
      '{1'b0, 1'b1, 1'b0, 1'b0, 3'h3, 12'h2BC, 12'h384, 1'b1, 1'b1},
      '{1'b0, 1'b1, 1'b0, 1'b0, 3'h7, 12'h2BC, 12'h064, 1'b1, 1'b0},
      '{1'b0, 1'b1, 1'b1, 1'b0, 3'h7, 12'h2BC, 12'h064, 1'b0, 1'b1},
      '{1'b0, 1'b1, 1'b0, 1'b1, 3'h7, 12'h2BC, 12'h064, 1'b0, 1'b1},
      '{1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 12'h000, 12'h3E8, 1'b0, 1'b1},
      '{1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 12'h7D0, 12'h4B0, 1'b0, 1'b0}
   };

   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic hsel = 1'b1;
   logic [2:0] hsize = 3'h2;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0;
   logic [2:0] channel_select_low = 3'h0;
   logic [11:0] pos_mv = 12'h000;
   logic [11:0] neg_mv = 12'h1F4;
   logic hwrite = 1'b0;
   logic converter_enable = 1'b0;
   logic channel_select_top = 1'b0;
   logic global_irq_enable = 1'b0;
   logic irq_vector_ack = 1'b0;
   logic cmp_positive_pin_in = 1'b0;
   logic cmp_negative_pin_in = 1'b0;
   logic hready, hreadyout, hresp, cmp_raw, cmp_power_off, bandgap_select;
   logic negative_mux_select, negative_pin_buffer_off, capture_input;
   logic positive_pin_buffer_off, cmp_positive_pin_read, cmp_irq;
   logic cmp_negative_pin_read;
   logic [2:0] negative_channel;
   logic [31:0] hrdata;
   logic [7:0] capture_edges, v, e;
   int mismatches = 0;
   int cmp_count = 0;

   // The single slave's ready is the bus ready.
   assign hready = hreadyout;

   analog_comparator_control dut (
      .mclk(mclk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .cmp_raw(cmp_raw),
      .cmp_positive_pin_in(cmp_positive_pin_in),
      .cmp_negative_pin_in(cmp_negative_pin_in),
      .converter_enable(converter_enable),
      .channel_select_top(channel_select_top),
      .channel_select_low(channel_select_low),
      .global_irq_enable(global_irq_enable),
      .irq_vector_ack(irq_vector_ack), .cmp_power_off(cmp_power_off),
      .bandgap_select(bandgap_select),
      .negative_mux_select(negative_mux_select),
      .negative_channel(negative_channel),
      .negative_pin_buffer_off(negative_pin_buffer_off),
      .positive_pin_buffer_off(positive_pin_buffer_off),
      .cmp_positive_pin_read(cmp_positive_pin_read),
      .cmp_negative_pin_read(cmp_negative_pin_read),
      .capture_input(capture_input), .cmp_irq(cmp_irq));
   cmp_analog_model partner (
      .cmp_power_off(cmp_power_off), .bandgap_select(bandgap_select),
      .negative_mux_select(negative_mux_select),
      .negative_channel(negative_channel), .capture_input(capture_input),
      .pos_mv(pos_mv), .neg_mv(neg_mv), .cmp_raw(cmp_raw),
      .capture_edges(capture_edges));

   // Free-running 20 MHz clock.
   initial
   begin
      forever #25 mclk = ~mclk;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude

   // Waits for ready under a bound so a stuck slave cannot hang the run.
   task automatic wait_ready();
      int n;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (hready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         mismatches++;
         conclude();
      end
   endtask : wait_ready

   // One single word transfer, entered just after a rising edge.
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] r);
      haddr <= a;
      hwrite <= w;
      htrans <= cmp_ctrl_pkg::HTRANS_NONSEQ;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      wait_ready();
      r = hrdata[7:0];
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      xfer(1'b1, a, d, r);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] r);
      xfer(1'b0, a, 8'h00, r);
   endtask : rd

   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
   endtask : idle

   // Brings the positive pin low and then high, with settling between.
   task automatic pulse_up();
      pos_mv <= 12'h000;
      idle(4);
      pos_mv <= 12'h3E8;
      idle(4);
   endtask : pulse_up

   // Main sequence: reset, table of analog setups, then the awkward cases.
   initial
   begin
      idle(2);
      rst <= 1'b0;
      idle(1);
      rd(cmp_ctrl_pkg::ADDR_CTRL_STATUS, v);
      `CHK(v, cmp_ctrl_pkg::RESET_CTRL_STATUS)
      rd(cmp_ctrl_pkg::ADDR_CONV_CTRL_B, v);
      `CHK(v, cmp_ctrl_pkg::RESET_CONV_CTRL_B)
      rd(cmp_ctrl_pkg::ADDR_PIN_DISABLE, v);
      `CHK(v, cmp_ctrl_pkg::RESET_PIN_DISABLE)
      `CHK({hreadyout, hresp, cmp_irq}, 3'h4)
      // An unmapped word ignores writes and reads zero.
      wr(8'h5C, 8'hFF);
      rd(8'h5C, v);
      `CHK(v, 8'h00)
      for (int i = 0; i < 8; i++)
      begin
         // Power reduction is taken as cleared before the mux is used.
         wr(cmp_ctrl_pkg::ADDR_CONV_CTRL_B, {1'b0, rows[i].mux, 6'h00});
         wr(cmp_ctrl_pkg::ADDR_CTRL_STATUS, {1'b0, rows[i].bg, 6'h00});
         converter_enable <= rows[i].cen;
         channel_select_top <= rows[i].top;
         channel_select_low <= rows[i].ch;
         pos_mv <= rows[i].vp;
         neg_mv <= rows[i].vn;
         // The wait also lets a newly selected bandgap settle.
         idle(4);
         rd(cmp_ctrl_pkg::ADDR_CTRL_STATUS, v);
         `CHK(v[cmp_ctrl_pkg::POS_RESULT], rows[i].res)
         `CHK(negative_mux_select, rows[i].sel)
         `CHK(negative_channel, rows[i].ch)
         `CHK(bandgap_select, rows[i].bg)
      end
      wr(cmp_ctrl_pkg::ADDR_CTRL_STATUS, 8'h10);
      neg_mv <= 12'h1F4;
      // Each mode is set with the interrupt disabled.
      for (int m = 0; m < 4; m++)
      begin
         wr(cmp_ctrl_pkg::ADDR_CTRL_STATUS, 8'h10 | 8'(m));
         pulse_up();
         rd(cmp_ctrl_pkg::ADDR_CTRL_STATUS, v);
         `CHK(v[4], (m == 0 || m == 3))
         wr(cmp_ctrl_pkg::ADDR_CTRL_STATUS, 8'h10 | 8'(m));
         pos_mv <= 12'h000;
         idle(4);
         rd(cmp_ctrl_pkg::ADDR_CTRL_STATUS, v);
         `CHK(v[4], (m == 0 || m == 2))
      end
      // Rising mode with the enable set but global enable low.
      wr(cmp_ctrl_pkg::ADDR_CTRL_STATUS, 8'h1B);
      pulse_up();
      `CHK(cmp_irq, 1'b0)
      global_irq_enable <= 1'b1;
      idle(2);
      `CHK(cmp_irq, 1'b1)
      irq_vector_ack <= 1'b1;
      idle(1);
      irq_vector_ack <= 1'b0;
      idle(2);
      `CHK(cmp_irq, 1'b0)
      pulse_up();
      `CHK(cmp_irq, 1'b1)
      wr(cmp_ctrl_pkg::ADDR_CTRL_STATUS, 8'h1B);
      idle(1);
      `CHK(cmp_irq, 1'b0)
      // With the enable clear the flag still sets but no request follows.
      wr(cmp_ctrl_pkg::ADDR_CTRL_STATUS, 8'h13);
      pulse_up();
      rd(cmp_ctrl_pkg::ADDR_CTRL_STATUS, v);
      `CHK({v[4], cmp_irq}, 2'h2)
      // Power off with the interrupt already disabled.
      wr(cmp_ctrl_pkg::ADDR_CTRL_STATUS, 8'h90);
      pulse_up();
      rd(cmp_ctrl_pkg::ADDR_CTRL_STATUS, v);
      `CHK({v[7], v[4], cmp_power_off}, 3'h5)
      wr(cmp_ctrl_pkg::ADDR_CTRL_STATUS, 8'h14);
      idle(5);
      `CHK(capture_input, 1'b1)
      pos_mv <= 12'h000;
      idle(5);
      e = capture_edges;
      pos_mv <= 12'h3E8;
      idle(2);
      `CHK(capture_input, 1'b0)
      idle(3);
      `CHK(capture_input, 1'b1)
      `CHK(capture_edges, e + 8'h01)
      wr(cmp_ctrl_pkg::ADDR_CTRL_STATUS, 8'h10);
      idle(2);
      `CHK(capture_input, 1'b0)
      cmp_positive_pin_in <= 1'b1;
      cmp_negative_pin_in <= 1'b1;
      wr(cmp_ctrl_pkg::ADDR_PIN_DISABLE, 8'hFF);
      idle(4);
      rd(cmp_ctrl_pkg::ADDR_PIN_DISABLE, v);
      `CHK(v, 8'h03)
      `CHK({negative_pin_buffer_off, positive_pin_buffer_off,
         cmp_negative_pin_read, cmp_positive_pin_read}, 4'hC)
      wr(cmp_ctrl_pkg::ADDR_PIN_DISABLE, 8'h01);
      idle(4);
      `CHK({negative_pin_buffer_off, positive_pin_buffer_off,
         cmp_negative_pin_read, cmp_positive_pin_read}, 4'h6)
      // Reset in mid-run with the comparator high: no event may follow.
      rst <= 1'b1;
      idle(2);
      `CHK({positive_pin_buffer_off, cmp_irq, hreadyout}, 3'h1)
      rst <= 1'b0;
      idle(4);
      rd(cmp_ctrl_pkg::ADDR_CTRL_STATUS, v);
      `CHK(v, 8'h20)
      // Clock enable low freezes the pin synchroniser and its read bit.
      ce <= 1'b0;
      cmp_positive_pin_in <= 1'b0;
      idle(5);
      `CHK(cmp_positive_pin_read, 1'b1)
      ce <= 1'b1;
      idle(4);
      `CHK(cmp_positive_pin_read, 1'b0)
      conclude();
   end
endmodule : analog_comparator_control_tb

/* tb/cmp_analog_model.sv */
// Behavioural model of the comparator front end and the timer capture input.
`timescale 1ns/1ps

module cmp_analog_model
#(
   // Bandgap level in millivolts; the value is a plain default.
   parameter logic [11:0] BANDGAP_MV = 12'h44C
)
(
   // Controls from the block.
   input wire logic cmp_power_off,
   input wire logic bandgap_select,
   input wire logic negative_mux_select,
   input wire logic [2:0] negative_channel,
   input wire logic capture_input,
   // Pin voltages in millivolts.
   input wire logic [11:0] pos_mv,
   input wire logic [11:0] neg_mv,
   // Comparator output and capture edge count.
   output logic cmp_raw,
   output logic [7:0] capture_edges
);
   logic [11:0] plus_mv;
   logic [11:0] minus_mv;

   // Converter pin N sits at N times 200 mV, so a wrong channel shows up.
   assign plus_mv = bandgap_select ? BANDGAP_MV : pos_mv;
   assign minus_mv = negative_mux_select ?
      12'(negative_channel) * 12'h0C8 : neg_mv;
   // An unpowered comparator drives low rather than its last decision.
   assign cmp_raw = !cmp_power_off && (plus_mv > minus_mv);

   // The capture front end counts rising edges of the routed result; its
   // interrupt also needs the timer's own capture enable, set there.
   initial capture_edges = 8'h00;
   always @(posedge capture_input)
      capture_edges <= capture_edges + 8'h01;
endmodule : cmp_analog_model
